/* File: hdl/mks_pkg.sv */
/*
 Constants shared by the matrix keypad scanner.
 Assumes a single 100 MHz clock domain and a synchronous active-low reset.
*/
// Functional notes
// RQ1 - Selection lines drive the eight low bits of the output word.
// RQ2 - Return lines sampled from input bits 0 to 7 under each selection.
// RQ3 - 64-bit image written to four consecutive 16-bit destination words.
// RQ4 - Full scan takes 24 scan cycles, then restarts continuously.
// RQ5 - Output bit 8 is a one-round flag, one cycle in every 24.
// RQ6 - On start of execution the scan begins at the first position.
// RQ7 - Program clears the work word before first-cycle use.
// RQ8 - No other function touches the scanner work word.
// RQ9 - I/O refreshed after each execution; input filter shorter than a cycle.
// RQ10 - One selection active at a time; row bits of selection k land at 8k.
package mks_pkg;
   // ===========================================================
   // Scan geometry and timing
   // ===========================================================
   localparam int unsigned MKS_LINES      = 8;
   localparam int unsigned MKS_ROUND      = 24;
   localparam int unsigned MKS_STEP_W     = 5;
   localparam int unsigned MKS_FLAG_BIT   = 8;
   localparam int unsigned MKS_OUT_W      = 16;
   localparam int unsigned MKS_WORD_W     = 16;
   localparam int unsigned MKS_WORDS      = 4;
   localparam int unsigned MKS_STEPS_SEL  = 3;
   localparam logic [4:0]  MKS_LAST_STEP  = 5'h17;
   localparam logic [15:0] MKS_OUT_RESET  = 16'h0000;
   localparam logic [15:0] MKS_WORD_RESET = 16'h0000;

   typedef enum logic [1:0] {
      MKS_IDLE = 2'b00,
      MKS_SCAN = 2'b01
   } mks_state_t;
endpackage

/* File: hdl/mks_sync.sv */
/*
 Two-flop synchroniser for a bus of asynchronous levels.
 Assumes the input is quasi-static compared with the clock.
*/
`timescale 1ns/100ps
module mks_sync #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

/* File: hdl/mks_scanner.sv */
/*
 Matrix keypad scanner: drives one of eight selection lines at a time, samples
 eight return lines, and builds a 64-bit image in four 16-bit words.
 Assumes a passive switch matrix; return lines are asynchronous pins.
 One scan step takes one clock while run_i is high (24 steps per round).
*/
`timescale 1ns/100ps
module mks_scanner
   import mks_pkg::*;
(
   input  wire logic                        clk_i,
   input  wire logic                        reset_n_i,
   input  wire logic                        run_i,
   input  wire logic [mks_pkg::MKS_LINES-1:0] return_i,
   output logic [mks_pkg::MKS_OUT_W-1:0]    out_word_o,
   output logic [mks_pkg::MKS_WORD_W-1:0]   dest0_o,
   output logic [mks_pkg::MKS_WORD_W-1:0]   dest1_o,
   output logic [mks_pkg::MKS_WORD_W-1:0]   dest2_o,
   output logic [mks_pkg::MKS_WORD_W-1:0]   dest3_o,
   output logic                             round_o,
   output logic                             operation_fault_flag_o
);
   import mks_pkg::*;

   // ===========================================================
   // Input synchronisation
   // ===========================================================
   logic [MKS_LINES-1:0] ret_sync;

   mks_sync #(
      .WIDTH (MKS_LINES)
   ) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (return_i),
      .sync_o    (ret_sync)
   );

   // ===========================================================
   // Scan sequencer
   // ===========================================================
   // A round is 8 selections of 3 steps: drive, settle, sample.
   // The settle step covers the two-flop delay on the return lines.
   mks_state_t            state_q, state_d;
   logic [MKS_STEP_W-1:0] step_q, step_d;
   logic                  start;
   logic                  active;
   logic                  wrap;
   logic [MKS_STEP_W-1:0] next_step;

   function automatic logic [2:0] sel_of(input logic [MKS_STEP_W-1:0] s);
      logic [MKS_STEP_W-1:0] q;
      q = s / MKS_STEP_W'(MKS_STEPS_SEL);
      return q[2:0];
   endfunction

   function automatic logic [1:0] phase_of(input logic [MKS_STEP_W-1:0] s);
      logic [MKS_STEP_W-1:0] r;
      r = s % MKS_STEP_W'(MKS_STEPS_SEL);
      return r[1:0];
   endfunction

   function automatic logic [MKS_STEP_W-1:0] step_after(input logic [MKS_STEP_W-1:0] s);
      logic [MKS_STEP_W-1:0] n;
      if (s == MKS_LAST_STEP) begin
         n = '0;
      end else begin
         n = s + MKS_STEP_W'(1);
      end
      return n;
   endfunction

   // Shared decode of where the sequencer stands this cycle
   always_comb begin
      start     = (state_q == MKS_IDLE) && run_i;
      active    = (state_q == MKS_SCAN) && run_i;
      wrap      = active && (step_q == MKS_LAST_STEP);
      next_step = step_after(step_q);
   end

   always_comb begin
      state_d = state_q;
      step_d  = step_q;
      unique case (state_q)
         MKS_IDLE: begin
            if (run_i) begin
               state_d = MKS_SCAN;
               step_d  = '0;                                   // [RQ6]
            end
         end
         MKS_SCAN: begin
            if (run_i) begin
               step_d = next_step;                             // [RQ4]
            end else begin
               // Position is dropped on purpose: a restart always begins a round
               state_d = MKS_IDLE;
            end
         end
         default: begin
            state_d = MKS_IDLE;
            step_d  = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_q <= MKS_IDLE;
         step_q  <= '0;
      end else begin
         state_q <= state_d;
         step_q  <= step_d;
      end
   end

   // ===========================================================
   // Selection word
   // ===========================================================
   // Built from the next step so the pins change with the step register
   logic [MKS_OUT_W-1:0] out_q, out_d;

   always_comb begin
      out_d = MKS_OUT_RESET;
      if (start) begin
         out_d[0] = 1'b1;                                      // [RQ1] [RQ6]
      end else if (active) begin
         out_d[sel_of(next_step)] = 1'b1;                      // [RQ1] [RQ10]
         out_d[MKS_FLAG_BIT]      = wrap;                      // [RQ5]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         out_q <= MKS_OUT_RESET;
      end else begin
         out_q <= out_d;
      end
   end

   // ===========================================================
   // Image capture
   // ===========================================================
   // The image is not cleared on stop; every row is rewritten in a round
   logic [63:0] img_q, img_d;
   logic [2:0]  cap_sel;
   logic        capture;

   always_comb begin
      cap_sel = sel_of(step_q);
      capture = active && (phase_of(step_q) == 2'h2);
      img_d   = img_q;
      if (capture) begin
         img_d[8*cap_sel +: 8] = ret_sync;                     // [RQ2] [RQ10]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         img_q <= '0;
      end else begin
         img_q <= img_d;
      end
   end

   // ===========================================================
   // Destination words
   // ===========================================================
   // All four words move together so a reader never sees a torn image
   logic [MKS_WORD_W-1:0] dst_q [MKS_WORDS];
   logic [MKS_WORD_W-1:0] dst_d [MKS_WORDS];

   always_comb begin
      dst_d = dst_q;
      if (wrap) begin
         for (int w = 0; w < MKS_WORDS; w++) begin
            dst_d[w] = img_d[16*w +: 16];                      // [RQ3]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         for (int w = 0; w < MKS_WORDS; w++) begin
            dst_q[w] <= MKS_WORD_RESET;
         end
      end else begin
         dst_q <= dst_d;
      end
   end

   // ===========================================================
   // Status flags
   // ===========================================================
   logic round_q, round_d;
   logic fault_q, fault_d;

   always_comb begin
      round_d = wrap;                                          // [RQ5]
      // This operation has no fault condition
      fault_d = 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         round_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         round_q <= round_d;
         fault_q <= fault_d;
      end
   end

   // ===========================================================
   // Outputs
   // ===========================================================
   assign out_word_o             = out_q;
   assign dest0_o                = dst_q[0];
   assign dest1_o                = dst_q[1];
   assign dest2_o                = dst_q[2];
   assign dest3_o                = dst_q[3];
   assign round_o                = round_q;
   assign operation_fault_flag_o = fault_q;
endmodule

/* File: dv/mks_matrix.sv */
/*
 Passive 8x8 switch matrix model.
 Assumes one-hot selection; closed key joins its column to its row.
*/
`timescale 1ns/100ps
module mks_matrix (
   input  wire logic [63:0] keys_i,
   input  wire logic [7:0]  select_i,
   output logic      [7:0]  return_o
);
   // Rows have pull-downs, so an unselected matrix reads all zero
   // No contact filtering: returns follow the selection at once
   always_comb begin
      return_o = 8'h00;
      for (int k = 0; k < 8; k++) begin
         if (select_i[k]) begin
            return_o = return_o | keys_i[8*k +: 8];
         end
      end
   end
endmodule

/* File: dv/mks_scanner_sva.sv */
/*
 Port checker for the matrix keypad scanner.
 Assumes the single clock and synchronous active-low reset of the scanner.
*/
`timescale 1ns/100ps
module mks_scanner_sva (
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        run_i,
   input wire logic [15:0] out_word_o,
   input wire logic [15:0] dest0_o,
   input wire logic [15:0] dest1_o,
   input wire logic [15:0] dest2_o,
   input wire logic [15:0] dest3_o,
   input wire logic        round_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   AST_ONE_SEL: assert property ($onehot0(out_word_o[7:0])) else $error("two selections");
   AST_TOP_ZERO: assert property (out_word_o[15:9] == 7'h00) else $error("stray bits");
   AST_FLAG_BIT: assert property (out_word_o[8] == round_o) else $error("flag split");
   AST_WRAP: assert property (round_o == (out_word_o[0] && $past(out_word_o[7])))
      else $error("flag not at wrap");
   AST_STANDS: assert property ($changed(out_word_o[7:0]) && |out_word_o[7:0] && run_i ##1 run_i
      |-> $stable(out_word_o[7:0]) ##1 $stable(out_word_o[7:0])) else $error("short select");
   AST_ASCEND: assert property ($changed(out_word_o[7:0]) && |out_word_o[7:1]
      |-> out_word_o[7:0] == $past(out_word_o[7:0]) << 1) else $error("order");
   AST_START: assert property (run_i && out_word_o[7:0] == 8'h00 |=> out_word_o == 16'h0001)
      else $error("bad start");
   AST_STOP: assert property (!run_i |=> out_word_o == 16'h0000) else $error("no stop");
   AST_HOLD: assert property (!round_o |-> $stable({dest3_o, dest2_o, dest1_o, dest0_o}))
      else $error("dest moved");
   cover property (round_o);
   cover property ($fell(run_i) && |out_word_o[7:0]);
   cover property (out_word_o == 16'h0101);
endmodule
bind mks_scanner mks_scanner_sva mks_scanner_sva_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .run_i(run_i), .out_word_o(out_word_o), .dest0_o(dest0_o), .dest1_o(dest1_o),
   .dest2_o(dest2_o), .dest3_o(dest3_o), .round_o(round_o));

/* File: dv/mks_scanner_test.sv */
/*
 Self-checking bench for the matrix keypad scanner.
 Assumes the scanner ports and the passive matrix model.
*/
`timescale 1ns/100ps
module mks_scanner_test;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        run_i = 1'b0;
   logic [63:0] keys = 64'h0;
   logic [63:0] nk;
   logic [63:0] expq[$];
   logic [7:0]  ret;
   logic [15:0] ow, d0, d1, d2, d3;
   logic        round;
   logic        fault;
   int          fail_count = 0;
   int          n_tests = 0;
   int          seed = 14;
   always #5 clk_i = ~clk_i;
   mks_scanner mks_scanner_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run_i),
      .return_i(ret), .out_word_o(ow), .dest0_o(d0), .dest1_o(d1), .dest2_o(d2),
      .dest3_o(d3), .round_o(round), .operation_fault_flag_o(fault));
   mks_matrix mks_matrix_i (.keys_i(keys), .select_i(ow[7:0]), .return_o(ret));
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (fail_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(negedge clk_i) begin
      if (round === 1'b1) begin
         check({d3, d2, d1, d0}, expq.pop_front());
      end
   end
   // Keys change only while stopped, so every finished round sees one image
   initial begin
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk_i);
         run_i <= 1'b0;
         nk = {$random(seed), $random(seed)};
         keys <= nk;
         expq.push_back(nk);
         repeat (3) @(posedge clk_i);
         run_i <= 1'b1;
         repeat (1 + ($unsigned($random(seed)) % 20)) @(posedge clk_i);
         run_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         run_i <= 1'b1;
         repeat (25) @(posedge clk_i);
         #1 check({63'h0, round}, 64'h1);
         check({63'h0, fault}, 64'h0);
      end
      close_out;
   end
   // About ten times the expected run length
   initial begin
      #50000;
      fail_count++;
      close_out;
   end
endmodule
